/* include/sgs_map.svh */
// Register map, field positions and counts for the GPIO and serial bus status bank
`ifndef SGS_MAP_SVH
`define SGS_MAP_SVH

`define SGS_ADR_W         12
`define SGS_OFS_ALT_SEL   12'h418
`define SGS_OFS_DIR_CFG   12'h41c
`define SGS_OFS_PIN_DATA  12'h420
`define SGS_OFS_STATUS    12'h424
`define SGS_OFS_IRQ_MASK  12'h440

`define SGS_PINS          16
`define SGS_BUS_ADDR_W    7
`define SGS_SADDR_LSB     1
`define SGS_MADDR_LSB     9
`define SGS_DONE_BIT      24
`define SGS_ERR_LSB       25
`define SGS_ERR_MSB       29
`define SGS_EVT_W         6

`define SGS_RST_ALT_SEL   16'h0000
`define SGS_RST_DIR_CFG   16'h0000
`define SGS_RST_PIN_DATA  16'h0000
`define SGS_RST_MASK      6'h00

`define SGS_ARB_LIMIT     5'h10
`define SGS_ARB_CNT_W     5

`endif

/* include/sgs_pkg.sv */
// Types shared by the GPIO and serial bus status bank
package sgs_pkg;

	// Error and completion pulses from the bus engine and ROM loader
	typedef struct packed {
		logic no_ack;
		logic misplaced;
		logic checksum;
		logic unmapped;
		logic rom_done;
	} sgs_evt_s;

	// Per-pin drive requested by the alternate functions
	typedef struct packed {
		logic [15:0] out;
		logic [15:0] oe_n;
	} sgs_alt_s;

	// Arbitration tracker state
	typedef enum logic [0:0] {
		SGS_ARB_IDLE,
		SGS_ARB_RETRY
	} sgs_arb_e;

endpackage

/* logic/sgs_regs.sv */
// GPIO control and serial bus status register bank behind a Wishbone slave
`timescale 1ns/1ps
`include "sgs_map.svh"

module sgs_regs (
	input  wire logic                        clk_sys_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [`SGS_ADR_W-1:0]       wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic [`SGS_PINS-1:0]        pin_in_i,
	output logic      [`SGS_PINS-1:0]        pin_out_o,
	output logic      [`SGS_PINS-1:0]        pin_oe_n_o,
	input  wire sgs_pkg::sgs_alt_s           alt_drive_i,
	output logic      [`SGS_PINS-1:0]        alt_in_o,
	input  wire logic [`SGS_BUS_ADDR_W-1:0]  slave_bus_address_i,
	input  wire logic [`SGS_BUS_ADDR_W-1:0]  master_bus_address_i,
	input  wire sgs_pkg::sgs_evt_s           evt_i,
	input  wire logic                        arb_lost_i,
	input  wire logic                        arb_won_i,
	output logic                             arb_retry_o,
	output logic                             arb_abort_o,
	output logic                             irq_o
);

	// Pin synchroniser, first stage read only by the second
	logic [`SGS_PINS-1:0] pin_meta_q;
	logic [`SGS_PINS-1:0] pin_s_q;

	always_ff @(posedge clk_sys_i) begin
		pin_meta_q <= pin_in_i;
		pin_s_q    <= pin_meta_q;
	end

	// Bus front end: one access taken per ack, ack drops the cycle after
	logic        req;
	logic        wr;
	logic        ack_d;
	logic        ack_q;
	logic [31:0] wmask;
	logic [31:0] rdat_d;
	logic [31:0] rdat_q;

	assign req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr  = req & wb_we_i;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// Register state
	logic [`SGS_PINS-1:0]       alt_sel_q;
	logic [`SGS_PINS-1:0]       alt_sel_d;
	logic [`SGS_PINS-1:0]       dir_q;
	logic [`SGS_PINS-1:0]       dir_d;
	logic [`SGS_PINS-1:0]       dout_q;
	logic [`SGS_PINS-1:0]       dout_d;
	logic [`SGS_BUS_ADDR_W-1:0] saddr_q;
	logic [`SGS_BUS_ADDR_W-1:0] maddr_q;
	logic                       done_q;
	logic                       done_d;
	logic [`SGS_ERR_MSB:`SGS_ERR_LSB] err_q;
	logic [`SGS_ERR_MSB:`SGS_ERR_LSB] err_d;
	logic [`SGS_ERR_MSB:`SGS_ERR_LSB] err_set;
	logic [`SGS_ERR_MSB:`SGS_ERR_LSB] err_clr;
	logic [`SGS_EVT_W-1:0]      mask_q;
	logic [`SGS_EVT_W-1:0]      mask_d;
	logic [`SGS_EVT_W-1:0]      stat_evt;
	logic [`SGS_PINS-1:0]       gp_out;
	logic [31:0]                status_word;
	logic                       lost_abort;

	// Arbitration tracker
	sgs_pkg::sgs_arb_e          arb_st_q;
	sgs_pkg::sgs_arb_e          arb_st_d;
	logic [`SGS_ARB_CNT_W-1:0]  arb_cnt_q;
	logic [`SGS_ARB_CNT_W-1:0]  arb_cnt_d;
	logic                       abort_d;
	logic                       abort_q;

	assign gp_out = ~alt_sel_q & dir_q;

	// Status word, reserved positions tied low
	// reserved bits zero
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`SGS_SADDR_LSB +: `SGS_BUS_ADDR_W] = saddr_q;
		status_word[`SGS_MADDR_LSB +: `SGS_BUS_ADDR_W] = maddr_q;
		status_word[`SGS_DONE_BIT] = done_q;
		status_word[`SGS_ERR_MSB:`SGS_ERR_LSB] = err_q;
	end

	// Read mux, unmapped addresses answer with zero
	always_comb begin
		rdat_d = rdat_q;
		if (req) begin
			unique case (wb_adr_i)
				`SGS_OFS_ALT_SEL:  rdat_d = {16'h0000, alt_sel_q};
				`SGS_OFS_DIR_CFG:  rdat_d = {16'h0000, dir_q};
				`SGS_OFS_PIN_DATA: rdat_d = {16'h0000, pin_s_q};
				`SGS_OFS_STATUS:   rdat_d = status_word;
				`SGS_OFS_IRQ_MASK: rdat_d = {2'h0, mask_q, 24'h00_0000};
				default:           rdat_d = 32'h0000_0000;
			endcase
		end
	end

	assign ack_d = req;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// GPIO control writes, upper halves are reserved and dropped
	always_comb begin
		alt_sel_d = alt_sel_q;
		dir_d     = dir_q;
		dout_d    = dout_q;
		if (wr && wb_adr_i == `SGS_OFS_ALT_SEL) begin
			alt_sel_d = (wb_dat_i[15:0] & wmask[15:0]) | (alt_sel_q & ~wmask[15:0]);
		end
		if (wr && wb_adr_i == `SGS_OFS_DIR_CFG) begin
			dir_d = (wb_dat_i[15:0] & wmask[15:0]) | (dir_q & ~wmask[15:0]);
		end
		// only GPIO outputs take the data
		if (wr && wb_adr_i == `SGS_OFS_PIN_DATA) begin
			dout_d = (wb_dat_i[15:0] & wmask[15:0] & gp_out)
				| (dout_q & ~(wmask[15:0] & gp_out));
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			alt_sel_q <= `SGS_RST_ALT_SEL;
			dir_q     <= `SGS_RST_DIR_CFG;
			dout_q    <= `SGS_RST_PIN_DATA;
		end else begin
			alt_sel_q <= alt_sel_d;
			dir_q     <= dir_d;
			dout_q    <= dout_d;
		end
	end

	// Pin steering; a GPIO input pin leaves its driver off, alternate pins take their enable from the function
	// alternate or GPIO select
	always_comb begin
		for (int k = 0; k < `SGS_PINS; k++) begin
			if (alt_sel_q[k]) begin
				pin_out_o[k]  = alt_drive_i.out[k];
				pin_oe_n_o[k] = alt_drive_i.oe_n[k];
			end else begin
				pin_out_o[k]  = dout_q[k];
				pin_oe_n_o[k] = ~dir_q[k];
			end
		end
	end

	assign alt_in_o = pin_s_q;

	// Straps are caught while reset is held and frozen after release
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			saddr_q <= slave_bus_address_i;
			maddr_q <= master_bus_address_i;
		end
	end

	// Consecutive lost arbitrations; a win or a abort restarts the count
	always_comb begin
		arb_st_d  = arb_st_q;
		arb_cnt_d = arb_cnt_q;
		abort_d   = 1'b0;
		unique case (arb_st_q)
			sgs_pkg::SGS_ARB_IDLE: begin
				if (arb_lost_i && !arb_won_i) begin
					arb_cnt_d = `SGS_ARB_CNT_W'(1);
					arb_st_d  = sgs_pkg::SGS_ARB_RETRY;
				end
			end
			sgs_pkg::SGS_ARB_RETRY: begin
				if (arb_won_i) begin
					arb_cnt_d = '0;
					arb_st_d  = sgs_pkg::SGS_ARB_IDLE;
				end else if (arb_lost_i) begin
					if (arb_cnt_q == `SGS_ARB_LIMIT - `SGS_ARB_CNT_W'(1)) begin
						abort_d   = 1'b1;
						arb_cnt_d = '0;
						arb_st_d  = sgs_pkg::SGS_ARB_IDLE;
					end else begin
						arb_cnt_d = arb_cnt_q + `SGS_ARB_CNT_W'(1);
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			arb_st_q  <= sgs_pkg::SGS_ARB_IDLE;
			arb_cnt_q <= '0;
			abort_q   <= 1'b0;
		end else begin
			arb_st_q  <= arb_st_d;
			arb_cnt_q <= arb_cnt_d;
			abort_q   <= abort_d;
		end
	end

	assign lost_abort = abort_d;
	// Retry is a handshake back to the engine, so it stays combinational
	// retry until limit
	assign arb_retry_o = arb_lost_i & ~arb_won_i & ~abort_d;
	assign arb_abort_o = abort_q;

	// Sticky flags: events set, write-one clears the error flags but not done, set wins the tie
	always_comb begin
		err_set = {evt_i.unmapped, evt_i.checksum, evt_i.misplaced, lost_abort, evt_i.no_ack};
		err_clr = '0;
		if (wr && wb_adr_i == `SGS_OFS_STATUS) begin
			err_clr = wb_dat_i[`SGS_ERR_MSB:`SGS_ERR_LSB] & wmask[`SGS_ERR_MSB:`SGS_ERR_LSB];
		end
		err_d  = (err_q & ~err_clr) | err_set;
		done_d = done_q | evt_i.rom_done;
		mask_d = mask_q;
		if (wr && wb_adr_i == `SGS_OFS_IRQ_MASK) begin
			mask_d = (wb_dat_i[`SGS_ERR_MSB:`SGS_DONE_BIT] & wmask[`SGS_ERR_MSB:`SGS_DONE_BIT])
				| (mask_q & ~wmask[`SGS_ERR_MSB:`SGS_DONE_BIT]);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			err_q  <= '0;
			done_q <= 1'b0;
			mask_q <= `SGS_RST_MASK;
		end else begin
			err_q  <= err_d;
			done_q <= done_d;
			mask_q <= mask_d;
		end
	end

	// Level interrupt from any unmasked status bit
	assign stat_evt = {err_q, done_q};
	assign irq_o    = |(stat_evt & mask_q);

	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	sequence seq_req_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence

	sequence seq_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	property prop_ack_once;
		seq_req_taken |=> seq_ack_pulse;
	endproperty

	chk_bus_ack_pulse: assert property (prop_ack_once)
		else $error("Ack not a single cycle after request");

	chk_alt_pin_owner: assert property (
		((pin_out_o ^ alt_drive_i.out) & alt_sel_q) == 16'h0000
		&& ((pin_oe_n_o ^ alt_drive_i.oe_n) & alt_sel_q) == 16'h0000)
		else $error("Alternate pin not driven by its function");

	chk_gpio_dir_drive: assert property (
		((pin_oe_n_o ^ ~dir_q) & ~alt_sel_q) == 16'h0000)
		else $error("GPIO enable disagrees with direction");

	chk_pin_read_live: assert property (
		seq_req_taken ##0 (!wb_we_i && wb_adr_i == `SGS_OFS_PIN_DATA)
		|=> wb_dat_o == {16'h0000, $past(pin_s_q)})
		else $error("Pin data read is not the pin level");

	chk_data_write_gp: assert property (
		seq_req_taken ##0 (wb_we_i && wb_adr_i == `SGS_OFS_PIN_DATA)
		|=> ((dout_q ^ $past(dout_q)) & ~$past(gp_out)) == 16'h0000)
		else $error("Write changed a pin that is not a GPIO output");

	chk_addr_frozen: assert property (
		$past(rst_n_i) |-> $stable(saddr_q) && $stable(maddr_q))
		else $error("Strapped bus address moved after reset");

	chk_noack_set: assert property (
		evt_i.no_ack |=> err_q[`SGS_ERR_LSB])
		else $error("No-ack event did not set its flag");

	chk_arb_abort_16: assert property (
		arb_st_q == sgs_pkg::SGS_ARB_RETRY && arb_lost_i && !arb_won_i
		&& arb_cnt_q == 5'h0f |=> arb_abort_o && err_q[`SGS_ERR_LSB + 1])
		else $error("Sixteenth lost arbitration did not abort");

	chk_flag_sticky: assert property (
		(err_q != '0) && !(wr && wb_adr_i == `SGS_OFS_STATUS) |=> (err_q & $past(err_q)) == $past(err_q))
		else $error("Error flag dropped without a clear");

	chk_done_hold: assert property (
		done_q |=> done_q)
		else $error("Load done bit fell outside reset");

	// GPIO registers keep their upper half empty; status has gaps at 0, 8 and 23:16
	chk_reserved_zero: assert property (
		wb_ack_o |-> wb_dat_o[31:30] == 2'h0
		&& ($past(wb_adr_i) > `SGS_OFS_PIN_DATA || wb_dat_o[31:16] == 16'h0000)
		&& ($past(wb_adr_i) != `SGS_OFS_STATUS
		|| (wb_dat_o[0] == 1'b0 && wb_dat_o[8] == 1'b0 && wb_dat_o[23:16] == 8'h00)))
		else $error("Reserved bit read as one");

	// A clear with no racing event must really drop the flag
	chk_flag_w1c: assert property (
		wr && wb_adr_i == `SGS_OFS_STATUS && wb_sel_i[3] && wb_dat_i[`SGS_ERR_LSB]
		&& !evt_i.no_ack |=> !err_q[`SGS_ERR_LSB])
		else $error("No-ack flag survived a write-one clear");

	// GPIO pins carry the data register, never a stale or alternate value
	chk_gpio_out_value: assert property (
		((pin_out_o ^ dout_q) & ~alt_sel_q) == 16'h0000)
		else $error("GPIO pin output differs from data register");

	chk_done_set: assert property (
		evt_i.rom_done |=> done_q)
		else $error("Load done pulse did not set its bit");

	chk_arb_retry: assert property (
		arb_lost_i && !arb_won_i && arb_cnt_q != (`SGS_ARB_LIMIT - 5'h01) |-> arb_retry_o)
		else $error("Lost arbitration below the limit not retried");

endmodule // sgs_regs

/* tb/tb.sv */
// Self-checking bench for the GPIO and serial bus status register bank
`timescale 1ns/1ps
`include "sgs_map.svh"

module tb;
	localparam logic [31:0] ST_BASE = {16'h0000, 7'h51, 1'b0, 7'h2b, 1'b0};

	logic                     clk_sys_i = 1'b0;
	logic                     rst_n_i = 1'b0;
	logic                     wb_cyc_i = 1'b0;
	logic                     wb_stb_i = 1'b0;
	logic                     wb_we_i = 1'b0;
	logic [`SGS_ADR_W-1:0]    wb_adr_i = '0;
	logic [3:0]               wb_sel_i = '0;
	logic [31:0]              wb_dat_i = '0;
	logic [31:0]              wb_dat_o;
	logic                     wb_ack_o;
	logic [15:0]              pin_in_i = 16'ha5c3;
	logic [15:0]              pin_out_o;
	logic [15:0]              pin_oe_n_o;
	sgs_pkg::sgs_alt_s        alt_drive_i = {16'h1234, 16'h5a5a};
	logic [15:0]              alt_in_o;
	sgs_pkg::sgs_evt_s        evt_i = '0;
	logic                     arb_lost_i = 1'b0;
	logic                     arb_won_i = 1'b0;
	logic                     arb_retry_o;
	logic                     arb_abort_o;
	logic                     irq_o;
	int                       fails = 0;
	int                       compares = 0;
	logic [31:0]              q;
	logic [31:0]              exp_st;
	int                       pos [5] = '{24, 29, 28, 27, 25};

	// Free-running system clock, 50 ns period
	always #25 clk_sys_i = ~clk_sys_i;

	sgs_regs dut (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
		.pin_oe_n_o(pin_oe_n_o), .alt_drive_i(alt_drive_i), .alt_in_o(alt_in_o),
		.slave_bus_address_i(7'h2b), .master_bus_address_i(7'h51), .evt_i(evt_i),
		.arb_lost_i(arb_lost_i), .arb_won_i(arb_won_i), .arb_retry_o(arb_retry_o),
		.arb_abort_o(arb_abort_o), .irq_o(irq_o)
	);

	task automatic conclude();
		$display("checks %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One classic cycle; the wait for ack is bounded so a dead slave cannot hang the run
	task automatic wb_cycle(input logic w, input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [31:0] r);
		int n;
		@(posedge clk_sys_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			fails++;
			conclude();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] dummy;
		wb_cycle(1'b1, a, d, s, dummy);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		wb_cycle(1'b0, a, 32'h0, 4'hf, r);
	endtask

	task automatic pulse(input sgs_pkg::sgs_evt_s e);
		@(posedge clk_sys_i);
		evt_i <= e;
		@(posedge clk_sys_i);
		evt_i <= '0;
	endtask

	// Lost pulses back to back; retry must drop exactly on the limit-th loss
	task automatic lose(input int n, input int lim);
		for (int k = 1; k <= n; k++) begin
			@(posedge clk_sys_i);
			arb_lost_i <= 1'b1;
			@(negedge clk_sys_i);
			check("retry", {31'h0, arb_retry_o}, {31'h0, k < lim});
		end
		@(posedge clk_sys_i);
		arb_lost_i <= 1'b0;
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd(12'h418, q);
		check("alt rst", q, 32'h0);
		rd(12'h41c, q);
		check("dir rst", q, 32'h0);
		rd(12'h440, q);
		check("mask rst", q, 32'h0);
		check("oe rst", {16'h0, pin_oe_n_o}, 32'hffff);
		rd(12'h424, q);
		check("status rst", q, ST_BASE);
		wr(12'h500, 32'hffffffff, 4'hf);
		rd(12'h500, q);
		check("unmapped", q, 32'h0);
		wr(12'h418, 32'hffffffff, 4'b0010);
		rd(12'h418, q);
		check("alt lane", q, 32'h0000ff00);
		wr(12'h41c, 32'hffffffff, 4'hf);
		rd(12'h41c, q);
		check("dir rsvd", q, 32'h0000ffff);
		wr(12'h418, 32'h000000f0, 4'hf);
		wr(12'h41c, 32'h00000f0f, 4'hf);
		wr(12'h420, 32'hffffffff, 4'hf);
		check("oe mix", {16'h0, pin_oe_n_o}, 32'h0000f050);
		check("out mix", {16'h0, pin_out_o & 16'h0ff0}, 32'h00000f30);
		// live read in any mode; new levels need two edges through the synchroniser
		rd(12'h420, q);
		check("pins", q, 32'h0000a5c3);
		pin_in_i <= 16'h3c96;
		wr(12'h418, 32'h0000ffff, 4'hf);
		rd(12'h420, q);
		check("pins alt", q, 32'h00003c96);
		check("alt in", {16'h0, alt_in_o}, 32'h00003c96);
		// data for non-output pins is not applied
		wr(12'h418, 32'h0, 4'hf);
		wr(12'h41c, 32'h0000ffff, 4'hf);
		check("out gpio", {16'h0, pin_out_o}, 32'h00000f0f);
		check("oe gpio", {16'h0, pin_oe_n_o}, 32'h0);
		exp_st = ST_BASE;
		for (int i = 0; i < 5; i++) begin
			pulse(sgs_pkg::sgs_evt_s'(5'h01 << i));
			exp_st[pos[i]] = 1'b1;
			rd(12'h424, q);
			check("status evt", q, exp_st);
			check("irq off", {31'h0, irq_o}, 32'h0);
		end
		wr(12'h440, 32'hffffffff, 4'hf);
		rd(12'h440, q);
		check("mask", q, 32'h3f000000);
		check("irq on", {31'h0, irq_o}, 32'h1);
		wr(12'h424, 32'h0, 4'hf);
		rd(12'h424, q);
		check("w1c zero", q, exp_st);
		// clear racing a new no-ack event; done bit ignores clears
		fork
			wr(12'h424, 32'hffffffff, 4'hf);
			pulse(5'h10);
		join
		exp_st[29:26] = 4'h0;
		rd(12'h424, q);
		check("w1c race", q, exp_st);
		// a lone clear on its byte lane drops the no-ack flag
		wr(12'h424, 32'h02000000, 4'h8);
		exp_st[25] = 1'b0;
		rd(12'h424, q);
		check("w1c lane", q, exp_st);
		check("irq done", {31'h0, irq_o}, 32'h1);
		wr(12'h440, 32'h0, 4'hf);
		check("irq mask", {31'h0, irq_o}, 32'h0);
		// a win restarts the count; 16 in a row abort
		lose(10, 99);
		@(posedge clk_sys_i);
		arb_won_i <= 1'b1;
		@(posedge clk_sys_i);
		arb_won_i <= 1'b0;
		lose(15, 99);
		lose(1, 1);
		@(negedge clk_sys_i);
		check("abort", {31'h0, arb_abort_o}, 32'h1);
		@(negedge clk_sys_i);
		check("abort end", {31'h0, arb_abort_o}, 32'h0);
		exp_st[26] = 1'b1;
		rd(12'h424, q);
		check("lost flag", q, exp_st);
		conclude();
	end
endmodule // tb
